/* File: logic/timer0_counter_reload_core.sv */
`timescale 1ns/1ns
`include "timer0_regs.svh"


module timer0_counter_reload_core
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // clock enables and system state
  input wire logic cpu_tick,
  input wire logic green_mode,
  // event pin
  input wire logic event_input_pin,
  // towards pwm, buzzer, interrupt and wake logic
  output logic overflow,
  output logic compare_match,
  output logic timer_irq,
  output logic wake_request,
  output logic event_wake_allow,
  output logic event_pin_irq,
  output logic pwm_enable,
  output logic toggle_enable
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  timer0_pkg::core_state_t state_reg;
  timer0_pkg::core_state_t state_next;
  logic presc_enable;
  logic presc_src_tick;
  logic [3:0] presc_exponent;
  logic presc_tick;
  logic event_fall;
  logic [7:0] index;
  logic bus_take;
  logic bus_write;
  logic step;
  logic hit;
  logic reload_on;
  logic [7:0] bound_mask;
  logic [7:0] read_mux;
  logic running;
  logic event_mode;
  logic pwm_on;

  // ****************************************************************
  // mode decode
  // ****************************************************************

  assign running = state_reg.mode.enb;
  // bit 3 selects the event pin
  // in event mode the rate and source select are ignored
  assign event_mode = state_reg.mode.cks;
  // pwm resolution applies only to the internal clock
  assign pwm_on = state_reg.mode.pwm && !event_mode;

  // ****************************************************************
  // clock sources
  // ****************************************************************

  // prescaler runs only for the internal source
  // rate ignored in event mode
  assign presc_enable = running && !event_mode;
  assign presc_src_tick = state_reg.src ? 1'b1 : cpu_tick;
  assign presc_exponent = state_reg.src ?
    (`EXP_HOSC_MAX - {1'b0, state_reg.mode.rate}) :
    (`EXP_CPU_MAX - {1'b0, state_reg.mode.rate});

  // divides the chosen source by two to the exponent
  timer0_prescaler u_prescaler
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(presc_enable),
    .src_tick(presc_src_tick),
    .exponent(presc_exponent),
    .tick(presc_tick)
  );

  timer0_event_sync u_event_sync
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(event_input_pin),
    .fall(event_fall)
  );

  // ****************************************************************
  // counting decisions
  // ****************************************************************

  assign step = running &&
    (event_mode ? event_fall : presc_tick);

  // boundary mask for the current mode
  // pwm resolution boundary
  always_comb
  begin
    bound_mask = `MASK_256;
    if (pwm_on)
    begin
      case ({state_reg.mode.aload, state_reg.mode.toggle})
        2'b00: bound_mask = `MASK_256;
        2'b01: bound_mask = `MASK_64;
        2'b10: bound_mask = `MASK_32;
        2'b11: bound_mask = `MASK_16;
        default: bound_mask = `MASK_256;
      endcase
    end
  end

  // overflow when the masked count is at full scale
  // bits above the boundary are don't care in pwm
  assign hit = step && ((state_reg.count & bound_mask) == bound_mask);

  assign reload_on = state_reg.mode.pwm || state_reg.mode.aload;

  // ****************************************************************
  // bus decode
  // ****************************************************************

  // word index of the byte address
  // address bits 1:0 are ignored, one register per word
  assign index = address[9:2];
  // a request is taken while waitrequest stands high
  assign bus_take = (read || write) && state_reg.waitreq;
  // a write lands on the edge that sees waitrequest low
  assign bus_write = write && !state_reg.waitreq;

  // read back, reload value is write only
  always_comb
  begin
    read_mux = `RST_BYTE;
    case (index)
      `IDX_RELOAD: read_mux = `RST_BYTE;
      `IDX_SELECT:
      begin
        read_mux[`SEL_GREEN_BIT] = state_reg.green;
        read_mux[`SEL_SRC_BIT] = state_reg.src;
      end
      `IDX_MODE: read_mux = state_reg.mode;
      `IDX_COUNT: read_mux = state_reg.count;
      // request flags and their enables share one byte
      `IDX_FLAGS:
      begin
        read_mux[`FLG_TIMER_BIT] = state_reg.tflag;
        read_mux[`FLG_TIEN_BIT] = state_reg.tien;
        read_mux[`FLG_EVPIN_BIT] = state_reg.evflag;
        read_mux[`FLG_EVIEN_BIT] = state_reg.evien;
      end
      default: read_mux = `RST_BYTE;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;

    // bus handshake, one cycle answer
    if (bus_take)
    begin
      state_next.waitreq = 1'b0;
      // the answer carries the value seen at the take edge
      state_next.rdata = read_mux;
    end
    else
    begin
      // idle or answering: busy again in the next cycle
      state_next.waitreq = 1'b1;
    end

    // counter advance and overflow reload
    if (step)
    begin
      if (hit)
      begin
        // holding moves to active
        // a reload write in this same cycle waits for the next overflow
        state_next.active = state_reg.hold;
        // new interval after overflow
        // without reload the count wraps to zero
        state_next.count = reload_on ? state_reg.hold : `RST_BYTE;
      end
      else
      begin
        state_next.count = state_reg.count + 8'h01;
      end
    end

    // register writes, clears before sets
    if (bus_write)
    begin
      case (index)
        `IDX_RELOAD:
        begin
          state_next.hold = writedata[7:0];
        end
        `IDX_SELECT:
        begin
          // unused select bits are dropped
          state_next.green = writedata[`SEL_GREEN_BIT];
          state_next.src = writedata[`SEL_SRC_BIT];
        end
        `IDX_MODE: state_next.mode = writedata[7:0];
        `IDX_COUNT: state_next.count = writedata[7:0];
        `IDX_FLAGS:
        begin
          // flag bits: zero clears, one keeps
          state_next.tflag = state_reg.tflag && writedata[`FLG_TIMER_BIT];
          state_next.tien = writedata[`FLG_TIEN_BIT];
          state_next.evflag = state_reg.evflag && writedata[`FLG_EVPIN_BIT];
          state_next.evien = writedata[`FLG_EVIEN_BIT];
        end
        // unmapped writes change nothing
        default: state_next.mode = state_reg.mode;
      endcase
    end

    if (hit)
    begin
      state_next.tflag = 1'b1;
    end

    // pin interrupt flag on falling edges in gpio use
    if (event_fall && !state_reg.mode.cks)
    begin
      state_next.evflag = 1'b1;
    end
    if (state_next.mode.cks)
    begin
      state_next.evflag = 1'b0;
    end

    // registered outputs
    state_next.out.overflow = hit;
    // compare match feeds the pwm duty generator
    state_next.out.compare_match = (state_next.count == state_next.active);
    state_next.out.timer_irq = state_next.tflag && state_next.tien;
    state_next.out.wake_request = hit && state_reg.green && green_mode;
    state_next.out.event_wake_allow = !state_next.mode.cks;
    state_next.out.event_pin_irq = state_next.evflag && state_next.evien &&
      !state_next.mode.cks;
    state_next.out.pwm_enable = state_next.mode.pwm;
    // buzzer toggle only counts outside pwm
    state_next.out.toggle_enable = state_next.mode.toggle && !state_next.mode.pwm;
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
      // bus idles busy, pin wake idles allowed
      state_reg.waitreq <= 1'b1;
      state_reg.out.event_wake_allow <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // bus answer, upper bytes read zero
  assign readdata = {24'h000000, state_reg.rdata};
  assign waitrequest = state_reg.waitreq;

  // timing events
  assign overflow = state_reg.out.overflow;
  assign compare_match = state_reg.out.compare_match;

  // requests towards interrupt and wake logic
  assign timer_irq = state_reg.out.timer_irq;
  assign wake_request = state_reg.out.wake_request;
  assign event_wake_allow = state_reg.out.event_wake_allow;
  assign event_pin_irq = state_reg.out.event_pin_irq;

  // waveform enables for pwm and buzzer
  assign pwm_enable = state_reg.out.pwm_enable;
  assign toggle_enable = state_reg.out.toggle_enable;

endmodule : timer0_counter_reload_core

/* File: logic/timer0_regs.svh */
`ifndef TIMER0_REGS_SVH
`define TIMER0_REGS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define IDX_RELOAD 8'hcd
`define IDX_SELECT 8'hd8
`define IDX_MODE 8'hda
`define IDX_COUNT 8'hdb
`define IDX_FLAGS 8'hdc

// ****************************************************************
// field positions
// ****************************************************************
`define SEL_GREEN_BIT 1
`define SEL_SRC_BIT 2
`define FLG_TIMER_BIT 0
`define FLG_TIEN_BIT 1
`define FLG_EVPIN_BIT 2
`define FLG_EVIEN_BIT 3

// ****************************************************************
// reset values, overflow boundary masks and prescaler exponent limits
// ****************************************************************
`define RST_BYTE 8'h00
`define MASK_256 8'hff
`define MASK_64 8'h3f
`define MASK_32 8'h1f
`define MASK_16 8'h0f
`define EXP_CPU_MAX 4'h8
`define EXP_HOSC_MAX 4'h7

`endif

/* File: logic/timer0_pkg.sv */
package timer0_pkg;

  // mode register layout, msb first
  typedef struct packed {
    logic enb;
    logic [2:0] rate;
    logic cks;
    logic aload;
    logic toggle;
    logic pwm;
  } mode_t;

  // prescaler state
  typedef struct packed {
    logic [7:0] cnt;
  } presc_state_t;

  // event pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  // outputs of the core towards the rest of the chip
  typedef struct packed {
    logic overflow;
    logic compare_match;
    logic timer_irq;
    logic wake_request;
    logic event_wake_allow;
    logic event_pin_irq;
    logic pwm_enable;
    logic toggle_enable;
  } core_out_t;

  // whole core state
  typedef struct packed {
    mode_t mode;
    logic green;
    logic src;
    logic [7:0] count;
    logic [7:0] hold;
    logic [7:0] active;
    logic tflag;
    logic tien;
    logic evflag;
    logic evien;
    logic waitreq;
    logic [7:0] rdata;
    core_out_t out;
  } core_state_t;

endpackage : timer0_pkg

/* File: logic/timer0_prescaler.sv */
`timescale 1ns/1ns
`include "timer0_regs.svh"

module timer0_prescaler
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic enable,
  input wire logic src_tick,
  input wire logic [3:0] exponent,
  // output
  output logic tick
);

  timer0_pkg::presc_state_t state_reg;
  timer0_pkg::presc_state_t state_next;
  logic [8:0] wide_mask;
  logic [7:0] mask;

  // divide mask of 2**exponent source ticks
  assign wide_mask = (9'h001 << exponent) - 9'h001;
  assign mask = wide_mask[7:0];
  assign tick = enable && src_tick && ((state_reg.cnt & mask) == mask);

  // free running count, cleared while stopped
  always_comb
  begin
    state_next = state_reg;
    if (!enable)
    begin
      state_next.cnt = `RST_BYTE;
    end
    else if (src_tick)
    begin
      state_next.cnt = state_reg.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : timer0_prescaler

/* File: logic/timer0_event_sync.sv */
`timescale 1ns/1ns

module timer0_event_sync
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // asynchronous pin
  input wire logic pin,
  // synchronised falling edge
  output logic fall
);

  timer0_pkg::sync_state_t state_reg;
  timer0_pkg::sync_state_t state_next;

  // edge seen only after the second stage
  assign fall = state_reg.s3 && !state_reg.s2;

  // two stage synchroniser plus edge history
  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pin;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
  end

  // state register, idle level high
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= 3'b111;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : timer0_event_sync

/* File: testbench/timer0_core_monitor.sv */
`timescale 1ns/1ns

module timer0_core_monitor
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // core outputs
  input wire logic overflow,
  input wire logic timer_irq,
  input wire logic wake_request,
  input wire logic event_wake_allow,
  input wire logic event_pin_irq,
  input wire logic pwm_enable,
  input wire logic toggle_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // bus answers once, one cycle after take
  answer_once_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not a single cycle");
  no_spont_a: assert property (!waitrequest |-> $past(read) || $past(write))
    else $error("bus answer without request");
  upper_zero_a: assert property (readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pin_mask_a: assert property (!event_wake_allow |-> !event_pin_irq)
    else $error("pin request while counting events");
  wake_cause_a: assert property (wake_request |-> overflow || $past(overflow))
    else $error("wake without overflow");
  toggle_pwm_a: assert property (toggle_enable |-> !pwm_enable)
    else $error("toggle output active in pwm");
  irq_cause_a: assert property ($rose(timer_irq) |-> overflow || $past(overflow) ||
    $past(overflow, 2) || !$past(waitrequest) || !$past(waitrequest, 2))
    else $error("timer request rose without cause");
  irq_hold_a: assert property ($fell(timer_irq) |-> !$past(waitrequest) ||
    !$past(waitrequest, 2) || !$past(waitrequest, 3))
    else $error("timer request dropped without write");
endmodule : timer0_core_monitor

bind timer0_counter_reload_core timer0_core_monitor mon_u (.ref_clk, .reset_n, .read, .write,
  .readdata, .waitrequest, .overflow, .timer_irq, .wake_request, .event_wake_allow,
  .event_pin_irq, .pwm_enable, .toggle_enable);

/* File: testbench/timer0_pulse_source.sv */
`timescale 1ns/1ns

module timer0_pulse_source
(
  // clock
  input wire logic ref_clk,
  // request
  input wire logic start,
  input wire logic [8:0] pulses,
  input wire logic [2:0] width,
  // pin and status
  output logic event_input_pin,
  output logic busy
);
  // pulse train, pin idles high, each level held width cycles
  initial
  begin
    event_input_pin = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (start)
      begin
        busy <= 1'b1;
        for (int i = 0; i < pulses; i++)
        begin
          event_input_pin <= 1'b0;
          repeat (width) @(posedge ref_clk);
          event_input_pin <= 1'b1;
          repeat (width) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : timer0_pulse_source

/* File: testbench/timer0_counter_reload_core_tb.sv */
`timescale 1ns/1ns
`include "timer0_regs.svh"

module timer0_counter_reload_core_tb;
  logic ref_clk, reset_n, read, write, cpu_tick, green_mode, event_input_pin;
  logic [9:0] address;
  logic [31:0] writedata, readdata, rd;
  logic waitrequest, overflow, compare_match, timer_irq, wake_request;
  logic event_wake_allow, event_pin_irq, pwm_enable, toggle_enable;
  logic go, busy, wake_seen;
  logic [8:0] npulse;
  logic [2:0] pw;
  logic [1:0] tick_cnt;
  int errors, checks_done, cycles;
  logic [7:0] cfg_mode [7] = '{8'h84, 8'hf6, 8'hf4, 8'hf7, 8'hf3, 8'hf5, 8'hf0};
  logic [7:0] cfg_sel [7] = '{8'h06, 8'h04, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04};
  // presets are boundary minus steps per interval, except the last entry, which wraps to zero without reload
  logic [7:0] cfg_rld [7] = '{8'hf0, 8'hf0, 8'hf0, 8'h0c, 8'h3c, 8'h1c, 8'hf0};
  int cfg_per [7] = '{2048, 16, 128, 4, 4, 4, 256};

  timer0_counter_reload_core dut_u (.ref_clk, .reset_n, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .cpu_tick, .green_mode, .event_input_pin, .overflow,
    .compare_match, .timer_irq, .wake_request, .event_wake_allow, .event_pin_irq,
    .pwm_enable, .toggle_enable);

  timer0_pulse_source src_u (.ref_clk, .start(go), .pulses(npulse), .width(pw),
    .event_input_pin, .busy);

  // ****************************************************************
  // clock, instruction tick and timeout
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // instruction tick every fourth cycle, run limit
  always @(posedge ref_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    cpu_tick <= (tick_cnt == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      results();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    check("bus answer", 1, n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wait_ovf(output int p);
    p = 0;
    do
    begin
      @(posedge ref_clk);
      p++;
      wake_seen |= wake_request;
    end
    while (overflow !== 1'b1 && p < 9000);
  endtask : wait_ovf

  task automatic pulse(input logic [8:0] k, input logic [2:0] w);
    int n;
    n = 0;
    npulse <= k;
    pw <= w;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (8) @(posedge ref_clk);
  endtask : pulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic reset_values();
    logic [7:0] idx [6] = '{`IDX_RELOAD, `IDX_SELECT, `IDX_MODE, `IDX_COUNT, `IDX_FLAGS, 8'h10};
    check("pin wake", 1, event_wake_allow);
    // registers clear, reload and unmapped read zero
    foreach (idx[i])
    begin
      bus(0, idx[i], 8'h00);
      check("reset read", 0, rd);
    end
  endtask : reset_values

  task automatic timer_modes();
    int p;
    for (int i = 0; i < 7; i++)
    begin
      bus(1, `IDX_MODE, 8'h00);
      bus(1, `IDX_SELECT, cfg_sel[i]);
      bus(1, `IDX_COUNT, cfg_rld[i]);
      bus(1, `IDX_RELOAD, cfg_rld[i]);
      bus(1, `IDX_FLAGS, 8'h02);
      bus(1, `IDX_MODE, cfg_mode[i]);
      wait_ovf(p);
      wake_seen = 1'b0;
      wait_ovf(p);
      check("period", cfg_per[i], p);
      check("wake", i == 0, wake_seen);
      check("timer irq", 1, timer_irq);
      check("compare", i != 6, compare_match);
      check("pwm", cfg_mode[i][0], pwm_enable);
      check("toggle", cfg_mode[i][1] && !cfg_mode[i][0], toggle_enable);
      if (i == 0)
      begin
        bus(1, `IDX_RELOAD, 8'he0);
        wait_ovf(p);
        bus(0, `IDX_COUNT, 8'h00);
        check("reloaded", 8'he0, rd);
        green_mode <= 1'b0;
        wake_seen = 1'b0;
        wait_ovf(p);
        wait_ovf(p);
        check("new period", 4096, p);
        check("green off", 0, wake_seen);
        green_mode <= 1'b1;
      end
    end
    bus(1, `IDX_FLAGS, 8'h02);
    @(posedge ref_clk);
    check("irq clear", 0, timer_irq);
  endtask : timer_modes

  task automatic event_count();
    bus(1, `IDX_MODE, 8'h00);
    bus(1, `IDX_FLAGS, 8'h0a);
    bus(1, `IDX_COUNT, 8'hfc);
    bus(1, `IDX_RELOAD, 8'hfc);
    bus(1, `IDX_MODE, 8'hfc);
    check("pin wake off", 0, event_wake_allow);
    pulse(9'd3, 3'h2);
    bus(0, `IDX_COUNT, 8'h00);
    check("events", 8'hff, rd);
    bus(0, `IDX_FLAGS, 8'h00);
    check("no overflow", 8'h0a, rd);
    pulse(9'd1, 3'h5);
    bus(0, `IDX_FLAGS, 8'h00);
    check("event overflow", 8'h0b, rd);
    bus(0, `IDX_COUNT, 8'h00);
    check("event reload", 8'hfc, rd);
    bus(1, `IDX_MODE, 8'h00);
    pulse(9'd1, 3'h3);
    bus(0, `IDX_COUNT, 8'h00);
    check("stopped", 8'hfc, rd);
    check("pin irq", 1, event_pin_irq);
  endtask : event_count

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    {reset_n, read, write, go, wake_seen} = '0;
    {address, writedata, npulse, tick_cnt, cpu_tick} = '0;
    {errors, checks_done, cycles} = '0;
    green_mode = 1'b1;
    pw = 3'h2;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    reset_values();
    timer_modes();
    event_count();
    results();
  end
endmodule : timer0_counter_reload_core_tb
